// File: shared/oscrs_pkg.sv
// Oscillator run and stabilization constants
package oscrs_pkg;
	localparam int          ADDR_W        = 20;
	localparam logic [19:0] ADDR_RUN_CTRL = 20'hFFFA1;
	localparam logic [19:0] ADDR_STAB_CNT = 20'hFFFA2;
	localparam logic [19:0] ADDR_STAB_SEL = 20'hFFFA3;

	localparam int          BIT_MAIN_HALT = 7;
	localparam int          BIT_SUB_HALT  = 6;
	localparam int          BIT_FAST_HALT = 0;
	localparam logic [7:0]  RUN_CTRL_RST  = 8'hC0;
	localparam logic [7:0]  STAB_CNT_RST  = 8'h00;
	localparam logic [2:0]  STAB_SEL_RST  = 3'h7;
	localparam int          STAB_SEL_W    = 3;

	localparam int          STAB_STEPS    = 8;
	localparam int          STAB_CNT_W    = 19;
	// Period exponents per length code and per status flag
	localparam logic [4:0]  STAB_EXP [STAB_STEPS] = '{5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0D, 5'h0F, 5'h11, 5'h12};

	function automatic logic [STAB_CNT_W-1:0] stabThreshold(input logic [2:0] idx);
		stabThreshold = STAB_CNT_W'(1) << STAB_EXP[idx];
	endfunction
endpackage

// File: src/oscrs_stab_counter.sv
// Main oscillator stabilization counter with thermometer status
`timescale 1ns/1ps
module oscrs_stab_counter
	import oscrs_pkg::*;
(
	input  wire logic                  ref_clk,
	input  wire logic                  rst_n,
	input  wire logic                  mainOscTick,
	input  wire logic                  clearCount,
	input  wire logic                  startCount,
	input  wire logic [STAB_SEL_W-1:0] stabLen,
	output logic      [STAB_STEPS-1:0] stabFlags,
	output logic                       stabDone
);
	import oscrs_pkg::*;

	logic                  running;
	logic [STAB_CNT_W-1:0] count;
	wire  [STAB_CNT_W-1:0] limit   = stabThreshold(stabLen);
	// Ticks only exist once the oscillator really swings, so start-up time is never counted
	wire                   doCount = running && mainOscTick && (count < limit);
	wire  [STAB_STEPS-1:0] reached;

	genvar i;
	generate
		for (i = 0; i < STAB_STEPS; i++) begin : g_flag
			// Flags beyond the selected length never set
			assign reached[i] = (count >= stabThreshold(3'(i))) && (3'(i) <= stabLen);
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			running   <= 1'b0;
			count     <= '0;
			stabFlags <= STAB_CNT_RST;
		end else if (clearCount) begin
			running   <= 1'b0;
			count     <= '0;
			stabFlags <= STAB_CNT_RST;
		end else begin
			if (startCount) begin
				running <= 1'b1;
			end
			if (doCount) begin
				count <= count + STAB_CNT_W'(1);
			end
			stabFlags <= stabFlags | reached;
		end
	end

	assign stabDone = stabFlags[stabLen];
endmodule

// File: src/oscrs_top.sv
// Oscillator run control and stabilization timing
`timescale 1ns/1ps
//
// Operation
// - Main halt bit stops main oscillator/external input
// - Sub halt bit stops sub oscillator/external input
// - Fast halt bit stops on-chip fast oscillator
// - Sub halt bit reset only by power-on
// - Status cleared: reset, stop entry, main halt
// - Counting starts on crystal start or stop exit
// - Flags set in turn and stay set
// - Counting limited to selected length
// - Length codes pick 2^8 through 2^18
// - Length select resets to seven
// - Main crystal clock held off until wait done
// - Start-up before oscillation is not counted
// - Count status read only, writes ignored
// - Length select takes byte writes only
// - Clock status: 0 main, 1 sub
// - Main status: 0 fast internal, 1 high-speed
module oscrs_top
	import oscrs_pkg::*;
(
	input  wire logic                      ref_clk,
	input  wire logic                      rst_n,
	input  wire logic                      porRst_n,
	input  wire logic [oscrs_pkg::ADDR_W-1:0] sfrAddr,
	input  wire logic                      sfrWrite,
	input  wire logic                      sfrBitOp,
	input  wire logic [7:0]                sfrWdata,
	input  wire logic                      sfrRead,
	output logic      [7:0]                sfrRdata,
	input  wire logic                      main_crystal_mode_select,
	input  wire logic                      main_external_clock_input,
	input  wire logic                      sub_external_clock_input,
	input  wire logic                      cpu_clock_source_status,
	input  wire logic                      main_source_status,
	input  wire logic                      mainOscTick,
	input  wire logic                      stopEnter,
	input  wire logic                      stopExit,
	output logic                           mainOscEnable,
	output logic                           mainExtClkAccept,
	output logic                           subOscEnable,
	output logic                           subExtClkAccept,
	output logic                           fastOscEnable,
	output logic                           mainClockReady,
	output logic                           stopPrecondFault
);
	import oscrs_pkg::*;

	logic                  main_osc_halt;
	logic                  sub_osc_halt;
	logic                  fast_internal_osc_halt;
	logic [STAB_SEL_W-1:0] stab_time_select;
	logic [STAB_STEPS-1:0] stab_count_status;
	logic                  stabDone;

	wire selRun   = (sfrAddr == ADDR_RUN_CTRL);
	wire selCnt   = (sfrAddr == ADDR_STAB_CNT);
	wire selLen   = (sfrAddr == ADDR_STAB_SEL);
	wire wrRun    = sfrWrite && selRun;
	// Bit manipulation on the length select is dropped
	wire wrLen    = sfrWrite && selLen && !sfrBitOp;
	wire mainHaltSet  = wrRun && sfrWdata[BIT_MAIN_HALT];
	wire mainHaltClr  = wrRun && !sfrWdata[BIT_MAIN_HALT] && main_osc_halt;
	wire crystalStart = mainHaltClr && main_crystal_mode_select && !main_external_clock_input;
	wire stabClear    = mainHaltSet || stopEnter;
	wire stabStart    = crystalStart || stopExit;
	wire [7:0] runView = {main_osc_halt, sub_osc_halt, 5'h00, fast_internal_osc_halt};
	wire [7:0] rdMux   = selRun ? runView :
	                     selCnt ? stab_count_status :
	                     selLen ? {5'h00, stab_time_select} : 8'h00;
	// Flags a halt of the clock the CPU is running on
	wire cpuOnHighSpeed = !cpu_clock_source_status && main_source_status;
	wire cpuOnFast      = !cpu_clock_source_status && !main_source_status;
	wire badStop = wrRun && ((sfrWdata[BIT_MAIN_HALT] && cpuOnHighSpeed) ||
	                         (sfrWdata[BIT_SUB_HALT] && cpu_clock_source_status) ||
	                         (sfrWdata[BIT_FAST_HALT] && cpuOnFast));

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			main_osc_halt          <= RUN_CTRL_RST[BIT_MAIN_HALT];
			fast_internal_osc_halt <= RUN_CTRL_RST[BIT_FAST_HALT];
		end else if (wrRun) begin
			main_osc_halt          <= sfrWdata[BIT_MAIN_HALT];
			fast_internal_osc_halt <= sfrWdata[BIT_FAST_HALT];
		end
	end

	// Only power-on reset touches this bit; other resets leave it alone
	always_ff @(posedge ref_clk or negedge porRst_n) begin
		if (!porRst_n) begin
			sub_osc_halt <= RUN_CTRL_RST[BIT_SUB_HALT];
		end else if (wrRun) begin
			sub_osc_halt <= sfrWdata[BIT_SUB_HALT];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			stab_time_select <= STAB_SEL_RST;
		end else if (wrLen) begin
			stab_time_select <= sfrWdata[STAB_SEL_W-1:0];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sfrRdata         <= 8'h00;
			stopPrecondFault <= 1'b0;
		end else begin
			if (sfrRead) begin
				sfrRdata <= rdMux;
			end
			// Sticky so software can inspect a misuse after the fact
			stopPrecondFault <= stopPrecondFault | badStop;
		end
	end

	oscrs_stab_counter u_stab (
		.ref_clk     (ref_clk),
		.rst_n       (rst_n),
		.mainOscTick (mainOscTick),
		.clearCount  (stabClear),
		.startCount  (stabStart),
		.stabLen     (stab_time_select),
		.stabFlags   (stab_count_status),
		.stabDone    (stabDone)
	);

	assign mainOscEnable    = !main_osc_halt && main_crystal_mode_select && !main_external_clock_input;
	assign mainExtClkAccept = !main_osc_halt && main_crystal_mode_select && main_external_clock_input;
	assign subOscEnable     = !sub_osc_halt && !sub_external_clock_input;
	assign subExtClkAccept  = !sub_osc_halt && sub_external_clock_input;
	assign fastOscEnable    = !fast_internal_osc_halt;
	// External clock needs no settling; crystal waits for the selected length
	assign mainClockReady   = mainExtClkAccept || (mainOscEnable && stabDone);
endmodule

// File: tb/oscrs_checker.sv
// Port assertions for oscillator run and stabilization
`timescale 1ns/1ps
module oscrs_checker
	import oscrs_pkg::*;
(
	input wire logic              ref_clk,
	input wire logic              rst_n,
	input wire logic [ADDR_W-1:0] sfrAddr,
	input wire logic              sfrWrite,
	input wire logic [7:0]        sfrWdata,
	input wire logic              sfrRead,
	input wire logic [7:0]        sfrRdata,
	input wire logic              main_crystal_mode_select,
	input wire logic              main_external_clock_input,
	input wire logic              cpu_clock_source_status,
	input wire logic              main_source_status,
	input wire logic              mainOscTick,
	input wire logic              stopEnter,
	input wire logic              stopExit,
	input wire logic              mainOscEnable,
	input wire logic              mainExtClkAccept,
	input wire logic              subOscEnable,
	input wire logic              subExtClkAccept,
	input wire logic              mainClockReady,
	input wire logic              stopPrecondFault
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	wire runWr = sfrWrite && sfrAddr == ADDR_RUN_CTRL;
	wire xtal = main_crystal_mode_select && !main_external_clock_input;
	a_main_halt: assert property (runWr && sfrWdata[7] |=> !mainOscEnable && !mainExtClkAccept)
		else $error("main clock kept after halt");
	a_main_run: assert property (runWr && !sfrWdata[7] && xtal |=> mainOscEnable)
		else $error("main crystal not started");
	a_sub_halt: assert property (runWr && sfrWdata[6] |=> !subOscEnable && !subExtClkAccept)
		else $error("sub clock kept after halt");
	a_halt_unready: assert property (runWr && sfrWdata[7] |=> !mainClockReady)
		else $error("ready after main halt");
	a_stop_clear: assert property (stopEnter && xtal |=> !mainClockReady)
		else $error("ready after stop entry");
	// Flag lands one cycle after the counting tick, so the tick is two samples back
	a_ready_cause: assert property ($rose(mainClockReady) && xtal |-> $past(mainOscTick, 2) || $past(sfrWrite))
		else $error("ready without tick");
	a_len_pad: assert property (sfrRead && sfrAddr == ADDR_STAB_SEL |=> sfrRdata[7:3] == 5'h00)
		else $error("length upper bits set");
	a_fault_set: assert property (runWr && sfrWdata[7] && !cpu_clock_source_status && main_source_status
		|=> stopPrecondFault)
		else $error("fault not flagged");
	a_fault_keep: assert property (stopPrecondFault |=> stopPrecondFault)
		else $error("fault dropped");
	c_ready: cover property (mainClockReady);
	c_fault: cover property (stopPrecondFault);
	c_exit: cover property (stopExit);
endmodule

// File: tb/oscrs_osc_model.sv
// Behavioural main crystal: silent start-up, then one tick per period
`timescale 1ns/1ps
module oscrs_osc_model (
	input  wire logic ref_clk,
	input  wire logic runEn,
	input  wire logic slow,
	output logic      mainOscTick = 1'b0
);
	int age = 0;
	// No ticks during start-up, so it can never be counted
	always @(posedge ref_clk) begin
		age <= runEn ? age + 1 : 0;
		mainOscTick <= runEn && age > 8 && age % (slow ? 4 : 2) == 0;
	end
endmodule

// File: tb/oscrs_top_tb.sv
// Self-checking bench for oscillator run and stabilization
`timescale 1ns/1ps
module oscrs_top_tb;
	import oscrs_pkg::*;
	logic ref_clk = 0, rst_n = 0, porRst_n = 0, sfrWrite = 0, sfrBitOp = 0, sfrRead = 0, slow = 0;
	// Pin mode fixed from time zero, before any run bit is written
	logic main_crystal_mode_select = 1, main_external_clock_input = 0, sub_external_clock_input = 0;
	logic cpu_clock_source_status = 1, main_source_status = 0, stopEnter = 0, stopExit = 0;
	logic [ADDR_W-1:0] sfrAddr = ADDR_RUN_CTRL;
	logic [7:0] sfrWdata = 8'h00, sfrRdata, q;
	logic mainOscTick, mainOscEnable, mainExtClkAccept, subOscEnable, subExtClkAccept;
	logic fastOscEnable, mainClockReady, stopPrecondFault;
	int num_errors = 0, checks_done = 0, ticks = 0, cyc = 0;
	// Rows: write, bit op, address, data, expected read
	// Last two rows set length before main start and halt main and fast, both off the CPU clock
	// CPU runs on the sub clock here until the halt test, and its settling is left to software
	logic [37:0] rows [9] = '{{2'b00, ADDR_RUN_CTRL, 16'h00C0}, {2'b00, ADDR_STAB_SEL, 16'h0007},
		{2'b00, ADDR_STAB_CNT, 16'h0000}, {2'b10, ADDR_STAB_SEL, 16'hFF07}, {2'b11, ADDR_STAB_SEL, 16'h0007},
		{2'b10, ADDR_STAB_CNT, 16'hFF00}, {2'b10, 20'hFFFA0, 16'h5500}, {2'b10, ADDR_STAB_SEL, 16'h0000},
		{2'b10, ADDR_RUN_CTRL, 16'h8181}};
	oscrs_top uut (.*);
	oscrs_osc_model osc (.ref_clk, .runEn(mainOscEnable || mainExtClkAccept), .slow, .mainOscTick);
	always #2 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		ticks += mainOscTick;
		// Whole run needs under 10000 cycles
		if (cyc == 20000) begin
			num_errors++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [19:0] a, input logic [7:0] d, input logic b);
		@(negedge ref_clk);
		{sfrAddr, sfrWdata, sfrBitOp, sfrWrite} = {a, d, b, 1'b1};
		@(negedge ref_clk);
		sfrWrite = 0;
	endtask
	task automatic rd(input logic [19:0] a, output logic [7:0] r);
		@(negedge ref_clk);
		{sfrAddr, sfrRead} = {a, 1'b1};
		@(negedge ref_clk);
		sfrRead = 0;
		r = sfrRdata;
	endtask
	task automatic waitReady();
		for (int k = 0; k < 8000 && mainClockReady !== 1'b1; k++) @(negedge ref_clk);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(negedge ref_clk);
		{rst_n, porRst_n} = 2'b11;
		foreach (rows[i]) begin
			if (rows[i][37]) wr(rows[i][35:16], rows[i][15:8], rows[i][36]);
			rd(rows[i][35:16], q);
			chk(q, rows[i][7:0]);
		end
		$display("test register rows done");
		chk({mainOscEnable, subOscEnable, fastOscEnable}, 3'b010);
		ticks = 0;
		wr(ADDR_RUN_CTRL, 8'h01, 0);
		waitReady();
		chk(ticks, 256);
		rd(ADDR_STAB_CNT, q);
		chk(q, 8'h01);
		wr(ADDR_STAB_SEL, 8'h02, 0);
		// Ticks while the counter sat at its limit were not counted
		ticks = 256;
		waitReady();
		chk(ticks, 1024);
		rd(ADDR_STAB_CNT, q);
		chk(q, 8'h07);
		$display("test count done");
		@(negedge ref_clk) stopEnter = 1;
		@(negedge ref_clk) stopEnter = 0;
		rd(ADDR_STAB_CNT, q);
		chk(q, 8'h00);
		slow = 1;
		@(negedge ref_clk) stopExit = 1;
		@(negedge ref_clk) stopExit = 0;
		waitReady();
		rd(ADDR_STAB_CNT, q);
		chk(q, 8'h07);
		$display("test stop done");
		{cpu_clock_source_status, main_source_status} = 2'b01;
		wr(ADDR_RUN_CTRL, 8'h81, 0);
		rd(ADDR_STAB_CNT, q);
		chk(q, 8'h00);
		chk({mainOscEnable, stopPrecondFault}, 2'b01);
		@(negedge ref_clk) rst_n = 0;
		@(negedge ref_clk) rst_n = 1;
		rd(ADDR_RUN_CTRL, q);
		chk(q, 8'h80);
		@(negedge ref_clk) {rst_n, porRst_n} = 2'b00;
		@(negedge ref_clk) {rst_n, porRst_n} = 2'b11;
		rd(ADDR_RUN_CTRL, q);
		chk(q, 8'hC0);
		$display("test halt and reset done");
		final_report();
	end
endmodule
bind oscrs_top oscrs_checker chk (.*);
